// >>> camera_ctrl_pkg.sv
// Purpose: shared constants, types and decode functions for the camera
//          image control register bank and its serial control link.
// Assumes: 8-bit registers, sub-addresses 0x00 to 0x0f backed by storage.
// Notes:   unmapped sub-addresses read as zero and ignore writes.
package camera_ctrl_pkg;

  // ----------------------------------------------------------------
  // serial control bus addressing
  // ----------------------------------------------------------------
  localparam logic [7:0] DEV_ADDR_WR = 8'h80;
  localparam logic [7:0] DEV_ADDR_RD = 8'h81;

  // ----------------------------------------------------------------
  // register offsets and values after reset
  // ----------------------------------------------------------------
  localparam int REG_DEPTH = 16;
  localparam logic [7:0] OFS_AGC_GAIN_VALUE = 8'h00;
  localparam logic [7:0] OFS_BLUE_GAIN_HIGH = 8'h01;
  localparam logic [7:0] OFS_RED_GAIN_HIGH = 8'h02;
  localparam logic [7:0] OFS_COLOUR_SATURATION_CTRL = 8'h03;
  localparam logic [7:0] OFS_HUE_ADJUST_CTRL = 8'h04;
  localparam logic [7:0] OFS_RESERVED_05 = 8'h05;
  localparam logic [7:0] OFS_BRIGHTNESS_LEVEL = 8'h06;
  localparam logic [7:0] OFS_SHARPEN_CTRL = 8'h07;
  localparam logic [7:0] OFS_COLOUR_GAIN_LOW_BITS = 8'h0a;
  localparam logic [7:0] OFS_EDGE_ENHANCE_CTRL = 8'h0e;
  localparam logic [7:0] RST_AGC_GAIN_VALUE = 8'h00;
  localparam logic [7:0] RST_BLUE_GAIN_HIGH = 8'h80;
  localparam logic [7:0] RST_RED_GAIN_HIGH = 8'h80;
  localparam logic [7:0] RST_COLOUR_SATURATION_CTRL = 8'h80;
  localparam logic [7:0] RST_HUE_ADJUST_CTRL = 8'h10;
  localparam logic [7:0] RST_BRIGHTNESS_LEVEL = 8'h80;
  localparam logic [7:0] RST_SHARPEN_CTRL = 8'hd4;
  localparam logic [7:0] RST_COLOUR_GAIN_LOW_BITS = 8'h00;
  localparam logic [7:0] RST_EDGE_ENHANCE_CTRL = 8'h96;
  localparam logic [7:0] RST_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BLUE_LSB_POS = 0;
  localparam int RED_LSB_POS = 4;
  localparam int SATURATION_POS = 4;
  localparam int HUE_EN_POS = 5;
  localparam int HUE_SET_POS = 0;
  localparam logic [4:0] HUE_ZERO_CODE = 5'h10;
  localparam int SHARPEN_THR_POS = 4;
  localparam int SHARPEN_AMT_POS = 0;
  localparam int EDGE_EN_POS = 7;

  // ----------------------------------------------------------------
  // link bit counts, one per serial clock rising edge in a frame
  // ----------------------------------------------------------------
  localparam logic [4:0] CNT_ID_LAST = 5'd7;
  localparam logic [4:0] CNT_ACK_ID = 5'd8;
  localparam logic [4:0] CNT_RD_FIRST = 5'd9;
  localparam logic [4:0] CNT_RD_LAST = 5'd16;
  localparam logic [4:0] CNT_SUB_LAST = 5'd16;
  localparam logic [4:0] CNT_ACK_SUB = 5'd17;
  localparam logic [4:0] CNT_DATA_LAST = 5'd25;
  localparam logic [4:0] CNT_ACK_DATA = 5'd26;
  localparam logic [4:0] CNT_DONE = 5'd27;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } wr_word_s;

  typedef struct packed {
    logic [7:0] agc_gain;
    logic [9:0] blue_gain;
    logic [9:0] red_gain;
    logic [3:0] saturation;
    logic hue_enable;
    logic signed [4:0] hue_offset;
    logic [7:0] brightness;
    logic [3:0] sharpen_threshold;
    logic [3:0] sharpen_amount;
    logic edge_enhance_en;
  } image_ctrl_s;

  // ----------------------------------------------------------------
  // decode functions
  // ----------------------------------------------------------------
  // documented registers; everything else is reserved
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == OFS_AGC_GAIN_VALUE) || (a == OFS_BLUE_GAIN_HIGH) ||
      (a == OFS_RED_GAIN_HIGH) || (a == OFS_COLOUR_SATURATION_CTRL) ||
      (a == OFS_HUE_ADJUST_CTRL) || (a == OFS_BRIGHTNESS_LEVEL) ||
      (a == OFS_SHARPEN_CTRL) || (a == OFS_COLOUR_GAIN_LOW_BITS) ||
      (a == OFS_EDGE_ENHANCE_CTRL);
  endfunction

  function automatic logic [7:0] reset_value(input logic [7:0] a);
    unique case (a)
      OFS_AGC_GAIN_VALUE: reset_value = RST_AGC_GAIN_VALUE;
      OFS_BLUE_GAIN_HIGH: reset_value = RST_BLUE_GAIN_HIGH;
      OFS_RED_GAIN_HIGH: reset_value = RST_RED_GAIN_HIGH;
      OFS_COLOUR_SATURATION_CTRL: reset_value = RST_COLOUR_SATURATION_CTRL;
      OFS_HUE_ADJUST_CTRL: reset_value = RST_HUE_ADJUST_CTRL;
      OFS_BRIGHTNESS_LEVEL: reset_value = RST_BRIGHTNESS_LEVEL;
      OFS_SHARPEN_CTRL: reset_value = RST_SHARPEN_CTRL;
      OFS_COLOUR_GAIN_LOW_BITS: reset_value = RST_COLOUR_GAIN_LOW_BITS;
      OFS_EDGE_ENHANCE_CTRL: reset_value = RST_EDGE_ENHANCE_CTRL;
      default: reset_value = RST_UNMAPPED;
    endcase
  endfunction

endpackage

// >>> camera_image_control_regs.sv
// Purpose: control register bank of the colour camera, reached over the
//          three-wire serial control bus, driving the image settings.
// Assumes: host frames each transfer with the enable pin low.
// Notes:   link logic runs on the serial clock; settings on CLK_SYS.
//
// How it works
// - answers slave bytes 0x80 write, 0x81 read
// - blue gain 10 bits, high byte plus LSBs
// - red gain 10 bits, high byte plus LSBs
// - saturation from bits 7 to 4
// - hue applied only when bit 5 set
// - hue code 10000 means zero shift
// - auto brightness overwrites brightness register
// - sharpen threshold high nibble, amount low
// - edge enhancement only when bit 7 set
// - transfers accepted only while enable is low
// - auto brightness follows its input pin
`timescale 1ns/1ps
module camera_image_control_regs (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic SERIAL_CTRL_CLOCK,
  input wire logic SERIAL_CTRL_DATA_IN,
  output logic SERIAL_CTRL_DATA_OUT,
  output logic SERIAL_CTRL_DATA_OE,
  input wire logic SERIAL_CTRL_ENABLE_N,
  input wire logic AUTO_BRIGHTNESS_PIN,
  input wire logic [7:0] AUTO_BRIGHTNESS_LEVEL,
  input wire logic FRAME_SYNC_INPUT,
  output logic FRAME_SYNC_PULSE,
  output camera_ctrl_pkg::image_ctrl_s IMAGE_CTRL
);
  import camera_ctrl_pkg::*;

  logic [7:0] reg_q [0:REG_DEPTH-1];
  logic [7:0] subaddr;
  logic sa_toggle;
  wr_word_s wr_word;
  logic wr_toggle;
  logic [2:0] sa_sync_q;
  logic [2:0] wr_sync_q;
  logic [1:0] bright_sync_q;
  logic [2:0] fsync_meta_q;
  logic sa_ev;
  logic wr_ev;
  logic auto_on;
  logic wr_allowed;
  logic refresh_q;
  logic [7:0] rd_word_q;
  logic fsync_q;
  image_ctrl_s ctrl_q;

  // ----------------------------------------------------------------
  // serial link, on the serial clock
  // ----------------------------------------------------------------
  serial_ctrl_link u_link (
    .scl(SERIAL_CTRL_CLOCK),
    .rst_b(RST_B),
    .en_n(SERIAL_CTRL_ENABLE_N),
    .sda_in(SERIAL_CTRL_DATA_IN),
    .rd_word(rd_word_q),
    .sda_out(SERIAL_CTRL_DATA_OUT),
    .sda_oe(SERIAL_CTRL_DATA_OE),
    .subaddr(subaddr),
    .sa_toggle(sa_toggle),
    .wr_word(wr_word),
    .wr_toggle(wr_toggle)
  );

  // ----------------------------------------------------------------
  // crossings into the system clock
  // ----------------------------------------------------------------
  // toggle synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      sa_sync_q <= 3'b000;
      wr_sync_q <= 3'b000;
    end else begin
      sa_sync_q <= {sa_sync_q[1:0], sa_toggle};
      wr_sync_q <= {wr_sync_q[1:0], wr_toggle};
    end
  end

  // event pulses; the words behind them are held still by the link
  assign sa_ev = sa_sync_q[1] ^ sa_sync_q[2];
  assign wr_ev = wr_sync_q[1] ^ wr_sync_q[2];

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      bright_sync_q <= 2'b00;
    end else begin
      bright_sync_q <= {bright_sync_q[0], AUTO_BRIGHTNESS_PIN};
    end
  end

  assign auto_on = bright_sync_q[1];

  // ----------------------------------------------------------------
  // frame sync input
  // ----------------------------------------------------------------
  // one pulse per frame
  // the host paces the pulses; this only marks each rising edge
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      fsync_meta_q <= 3'b000;
      fsync_q <= 1'b0;
    end else begin
      fsync_meta_q <= {fsync_meta_q[1:0], FRAME_SYNC_INPUT};
      fsync_q <= fsync_meta_q[1] & ~fsync_meta_q[2];
    end
  end

  assign FRAME_SYNC_PULSE = fsync_q;

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  // reserved addresses not written
  // host brightness write lost while auto runs
  assign wr_allowed = wr_ev && is_mapped(wr_word.addr) &&
    !(auto_on && wr_word.addr == OFS_BRIGHTNESS_LEVEL);

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < REG_DEPTH; i++) begin
        reg_q[i] <= reset_value(8'(i));
      end
    end else begin
      if (wr_allowed) begin
        reg_q[wr_word.addr[3:0]] <= wr_word.data;
      end
      if (auto_on) begin
        reg_q[OFS_BRIGHTNESS_LEVEL[3:0]] <= AUTO_BRIGHTNESS_LEVEL;
      end
    end
  end

  // ----------------------------------------------------------------
  // read-back word for the link
  // ----------------------------------------------------------------
  // refreshed only on link events so it stays still during a read
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      refresh_q <= 1'b0;
    end else begin
      refresh_q <= sa_ev | wr_ev;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      rd_word_q <= 8'h00;
    end else if (refresh_q) begin
      if (is_mapped(subaddr)) begin
        rd_word_q <= reg_q[subaddr[3:0]];
      end else begin
        rd_word_q <= RST_UNMAPPED;
      end
    end
  end

  // ----------------------------------------------------------------
  // image settings outputs
  // ----------------------------------------------------------------
  // gain joins and field picks for every setting
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_q <= '0;
    end else begin
      ctrl_q.agc_gain <= reg_q[OFS_AGC_GAIN_VALUE[3:0]];
      ctrl_q.blue_gain <= {reg_q[OFS_BLUE_GAIN_HIGH[3:0]],
        reg_q[OFS_COLOUR_GAIN_LOW_BITS[3:0]][BLUE_LSB_POS +: 2]};
      ctrl_q.red_gain <= {reg_q[OFS_RED_GAIN_HIGH[3:0]],
        reg_q[OFS_COLOUR_GAIN_LOW_BITS[3:0]][RED_LSB_POS +: 2]};
      ctrl_q.saturation <=
        reg_q[OFS_COLOUR_SATURATION_CTRL[3:0]][SATURATION_POS +: 4];
      ctrl_q.hue_enable <= reg_q[OFS_HUE_ADJUST_CTRL[3:0]][HUE_EN_POS];
      if (reg_q[OFS_HUE_ADJUST_CTRL[3:0]][HUE_EN_POS]) begin
        ctrl_q.hue_offset <= $signed(
          reg_q[OFS_HUE_ADJUST_CTRL[3:0]][HUE_SET_POS +: 5] ^ HUE_ZERO_CODE);
      end else begin
        ctrl_q.hue_offset <= 5'sd0;
      end
      ctrl_q.brightness <= reg_q[OFS_BRIGHTNESS_LEVEL[3:0]];
      ctrl_q.sharpen_threshold <=
        reg_q[OFS_SHARPEN_CTRL[3:0]][SHARPEN_THR_POS +: 4];
      ctrl_q.sharpen_amount <=
        reg_q[OFS_SHARPEN_CTRL[3:0]][SHARPEN_AMT_POS +: 4];
      ctrl_q.edge_enhance_en <=
        reg_q[OFS_EDGE_ENHANCE_CTRL[3:0]][EDGE_EN_POS];
    end
  end

  assign IMAGE_CTRL = ctrl_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb_sys @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);

  sequence s_wr(logic [7:0] a);
    wr_ev && (wr_word.addr == a);
  endsequence

  property p_blue_high;
    logic [7:0] d;
    (s_wr(OFS_BLUE_GAIN_HIGH), d = wr_word.data) |->
      ##2 ctrl_q.blue_gain[9:2] == d;
  endproperty
  a_blue_high: assert property (p_blue_high)
    else $error("blue gain high byte not applied");

  property p_gain_low;
    logic [7:0] d;
    (s_wr(OFS_COLOUR_GAIN_LOW_BITS), d = wr_word.data) |->
      ##2 (ctrl_q.blue_gain[1:0] == d[1:0]);
  endproperty
  a_gain_low: assert property (p_gain_low)
    else $error("blue gain low bits not applied");

  property p_red_gain;
    logic [7:0] d;
    (s_wr(OFS_COLOUR_GAIN_LOW_BITS), d = wr_word.data) ##1
      (!wr_ev)[*1] |-> ##1 (ctrl_q.red_gain[1:0] == d[5:4]);
  endproperty
  a_red_gain: assert property (p_red_gain)
    else $error("red gain low bits not applied");

  property p_saturation;
    logic [7:0] d;
    (s_wr(OFS_COLOUR_SATURATION_CTRL), d = wr_word.data) |->
      ##2 ctrl_q.saturation == d[7:4];
  endproperty
  a_saturation: assert property (p_saturation)
    else $error("saturation nibble not applied");

  property p_hue_bypass;
    !ctrl_q.hue_enable |-> (ctrl_q.hue_offset == 5'sd0);
  endproperty
  a_hue_bypass: assert property (p_hue_bypass)
    else $error("hue shift applied while hue is off");

  property p_hue_centre;
    (wr_ev && wr_word.addr == OFS_HUE_ADJUST_CTRL &&
      wr_word.data[HUE_EN_POS] && wr_word.data[4:0] == HUE_ZERO_CODE) |->
      ##2 (ctrl_q.hue_enable && ctrl_q.hue_offset == 5'sd0);
  endproperty
  a_hue_centre: assert property (p_hue_centre)
    else $error("centre hue code does not give zero shift");

  property p_auto_brightness;
    auto_on[*3] |-> ctrl_q.brightness == $past(AUTO_BRIGHTNESS_LEVEL, 2);
  endproperty
  a_auto_brightness: assert property (p_auto_brightness)
    else $error("auto brightness level not followed");

  property p_manual_hold;
    (!auto_on && !wr_ev)[*3] |-> $stable(ctrl_q.brightness);
  endproperty
  a_manual_hold: assert property (p_manual_hold)
    else $error("brightness changed with auto off and no write");

  property p_sharpen;
    logic [7:0] d;
    (s_wr(OFS_SHARPEN_CTRL), d = wr_word.data) |->
      ##2 (ctrl_q.sharpen_threshold == d[7:4] &&
        ctrl_q.sharpen_amount == d[3:0]);
  endproperty
  a_sharpen: assert property (p_sharpen)
    else $error("sharpen fields not applied");

  property p_edge;
    logic [7:0] d;
    (s_wr(OFS_EDGE_ENHANCE_CTRL), d = wr_word.data) |->
      ##2 ctrl_q.edge_enhance_en == d[7];
  endproperty
  a_edge: assert property (p_edge)
    else $error("edge enhance enable not applied");

  property p_reserved_05_read;
    (refresh_q && !is_mapped(subaddr)) |=> rd_word_q == 8'h00;
  endproperty
  a_reserved_05_read: assert property (p_reserved_05_read)
    else $error("reserved address did not read zero");

  // auto level must land even when a host write arrives together
  property p_auto_wins;
    (wr_ev && auto_on && wr_word.addr == OFS_BRIGHTNESS_LEVEL) |=>
      reg_q[OFS_BRIGHTNESS_LEVEL[3:0]] == $past(AUTO_BRIGHTNESS_LEVEL);
  endproperty
  a_auto_wins: assert property (p_auto_wins)
    else $error("host brightness write beat auto brightness");

  // a held sync level must not stretch the pulse
  property p_fsync_single;
    fsync_q |=> !fsync_q;
  endproperty
  a_fsync_single: assert property (p_fsync_single)
    else $error("frame sync pulse longer than one cycle");

endmodule

// >>> host_model.sv
// Purpose: serial control bus master standing in for the host controller.
// Assumes: wire has a pull-up; released bit reads 1.
// Notes:   bus clock idles high and only runs inside frames.
`timescale 1ns/1ps
module host_model (
  output logic scl,
  output logic en_n,
  output logic sda_drv,
  input wire logic sda
);
  // ----------------------------------------------------------------
  // idle state: clock still, enable high, data released
  // ----------------------------------------------------------------
  initial begin
    scl = 1'b1;
    en_n = 1'b1;
    sda_drv = 1'b1;
  end

  // one bit slot: change data after the fall, sample at the rise
  task automatic slot(input logic v, output logic s);
    #6 scl = 1'b0;
    sda_drv = v;
    #6 scl = 1'b1;
    s = sda;
  endtask

  // enable-framed transfer
  // bytes go MSB first; each byte is followed by a released ack slot.
  // a read slave byte releases the wire for the bytes after it.
  task automatic xfer(input logic [23:0] w, input int n, input logic en,
                      output logic [7:0] rd, output logic [2:0] ack);
    logic s;
    logic rdm;
    rdm = w[16];
    ack = 3'b000;
    rd = 8'h00;
    en_n = ~en;
    #6 sda_drv = 1'b0;
    for (int i = 0; i < n; i++) begin
      for (int b = 7; b >= 0; b--) begin
        slot((rdm && i > 0) ? 1'b1 : w[23 - 8 * i - (7 - b)], s);
        rd = {rd[6:0], s};
      end
      slot(1'b1, s);
      ack = {ack[1:0], s};
    end
    // stop: its extra rising edge is ignored by the device
    #6 scl = 1'b0;
    sda_drv = 1'b0;
    #6 scl = 1'b1;
    #6 sda_drv = 1'b1;
    #6 en_n = 1'b1;
  endtask
endmodule

// >>> serial_ctrl_link.sv
// Purpose: serial control bus slave engine, clocked by the bus clock.
// Assumes: one transfer per enable-low frame; enable high clears the frame.
// Notes:   sub-address and write word are held here for the system side.
`timescale 1ns/1ps
module serial_ctrl_link (
  input wire logic scl,
  input wire logic rst_b,
  input wire logic en_n,
  input wire logic sda_in,
  input wire logic [7:0] rd_word,
  output logic sda_out,
  output logic sda_oe,
  output logic [7:0] subaddr,
  output logic sa_toggle,
  output camera_ctrl_pkg::wr_word_s wr_word,
  output logic wr_toggle
);
  import camera_ctrl_pkg::*;

  logic frame_rst_n;
  logic [4:0] cnt_q;
  logic [6:0] shift_q;
  logic wr_ok_q;
  logic rd_ok_q;
  logic [7:0] byte_in;
  logic ack_slot;
  logic rd_slot;

  // ----------------------------------------------------------------
  // frame framing and bit capture
  // ----------------------------------------------------------------
  // enable high holds frame logic in reset
  assign frame_rst_n = rst_b & ~en_n;
  assign byte_in = {shift_q, sda_in};

  // bit counter saturates so the stop edge is harmless
  always_ff @(posedge scl or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      cnt_q <= 5'd0;
    end else if (cnt_q != CNT_DONE) begin
      cnt_q <= cnt_q + 5'd1;
    end
  end

  always_ff @(posedge scl or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      shift_q <= 7'd0;
    end else begin
      shift_q <= byte_in[6:0];
    end
  end

  always_ff @(posedge scl or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      wr_ok_q <= 1'b0;
      rd_ok_q <= 1'b0;
    end else if (cnt_q == CNT_ID_LAST) begin
      wr_ok_q <= (byte_in == DEV_ADDR_WR);
      rd_ok_q <= (byte_in == DEV_ADDR_RD);
    end
  end

  // ----------------------------------------------------------------
  // words handed to the system clock
  // ----------------------------------------------------------------
  // sub-address then data byte
  // kept across frames so a later read transfer uses it
  always_ff @(posedge scl or negedge rst_b) begin
    if (!rst_b) begin
      subaddr <= 8'h00;
      sa_toggle <= 1'b0;
    end else if (wr_ok_q && cnt_q == CNT_SUB_LAST) begin
      subaddr <= byte_in;
      sa_toggle <= ~sa_toggle;
    end
  end

  always_ff @(posedge scl or negedge rst_b) begin
    if (!rst_b) begin
      wr_word <= '0;
      wr_toggle <= 1'b0;
    end else if (wr_ok_q && cnt_q == CNT_DATA_LAST) begin
      wr_word <= '{addr: subaddr, data: byte_in};
      wr_toggle <= ~wr_toggle;
    end
  end

  // ----------------------------------------------------------------
  // data line drive on the falling edge
  // ----------------------------------------------------------------
  assign ack_slot = ((cnt_q == CNT_ACK_ID) && (wr_ok_q || rd_ok_q)) ||
    (((cnt_q == CNT_ACK_SUB) || (cnt_q == CNT_ACK_DATA)) && wr_ok_q);
  assign rd_slot = rd_ok_q && (cnt_q >= CNT_RD_FIRST) &&
    (cnt_q <= CNT_RD_LAST);

  // rd_word is settled long before the read frame, so no resync here
  always_ff @(negedge scl or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      sda_out <= 1'b1;
      sda_oe <= 1'b0;
    end else if (ack_slot) begin
      sda_out <= 1'b0;
      sda_oe <= 1'b1;
    end else if (rd_slot) begin
      sda_out <= rd_word[3'(CNT_RD_LAST - cnt_q)];
      sda_oe <= 1'b1;
    end else begin
      sda_out <= 1'b1;
      sda_oe <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_ack_own_addr;
    @(posedge scl) disable iff (!frame_rst_n)
      (cnt_q == CNT_ACK_ID && sda_oe && !sda_out) |-> (wr_ok_q || rd_ok_q);
  endproperty
  a_ack_own_addr: assert property (p_ack_own_addr)
    else $error("acknowledge given to a foreign slave address");

  property p_subaddr_take;
    @(posedge scl) disable iff (!frame_rst_n)
      (wr_ok_q && cnt_q == CNT_SUB_LAST) |=>
        (subaddr == $past(byte_in)) && (sa_toggle != $past(sa_toggle));
  endproperty
  a_subaddr_take: assert property (p_subaddr_take)
    else $error("sub-address byte not captured");

endmodule

// >>> tb.sv
// Purpose: self-checking bench for the camera control register bank.
// Assumes: design settles writes within 12 system cycles.
// Notes:   every scenario is a task that judges its own results.
`timescale 1ns/1ps
module tb;
  import camera_ctrl_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic abp = 1'b0;
  logic fsync_in = 1'b0;
  logic [7:0] abl = 8'h00;
  logic scl, en_n, sda_drv, sda_out, sda_oe, fs_pulse, sda;
  image_ctrl_s ic;
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  logic [7:0] rd;
  logic [2:0] ack;

  // wired-and data line with pull-up
  assign sda = sda_drv & (sda_oe ? sda_out : 1'b1);

  host_model i_host (.scl(scl), .en_n(en_n), .sda_drv(sda_drv), .sda(sda));

  camera_image_control_regs i_dut (
    .CLK_SYS(clk), .RST_B(rst_b), .SERIAL_CTRL_CLOCK(scl),
    .SERIAL_CTRL_DATA_IN(sda), .SERIAL_CTRL_DATA_OUT(sda_out),
    .SERIAL_CTRL_DATA_OE(sda_oe), .SERIAL_CTRL_ENABLE_N(en_n),
    .AUTO_BRIGHTNESS_PIN(abp), .AUTO_BRIGHTNESS_LEVEL(abl),
    .FRAME_SYNC_INPUT(fsync_in), .FRAME_SYNC_PULSE(fs_pulse), .IMAGE_CTRL(ic)
  );

  // ----------------------------------------------------------------
  // clock, hang guard and checking helpers
  // ----------------------------------------------------------------
  initial begin
    forever #20 clk = ~clk;
  end

  // a few thousand cycles is ample; a hang ends in the verdict
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.xfer({DEV_ADDR_WR, a, d}, 3, 1'b1, rd, ack);
    chk("write ack", 16'h0000, 16'(ack));
    repeat (12) @(negedge clk);
  endtask

  // sub-address frame, then a separate read frame
  task automatic rdr(input logic [7:0] a, output logic [7:0] d);
    i_host.xfer({DEV_ADDR_WR, a, 8'h00}, 2, 1'b1, rd, ack);
    repeat (12) @(negedge clk);
    i_host.xfer({DEV_ADDR_RD, 16'hffff}, 2, 1'b1, d, ack);
    chk("read ack", 16'h0000, 16'(ack[1]));
    repeat (12) @(negedge clk);
  endtask

  task automatic wrap_up();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] exp [16];
    logic [7:0] d;
    exp = '{8'h00, 8'h80, 8'h80, 8'h80, 8'h10, 8'h00, 8'h80, 8'hd4,
            8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h96, 8'h00};
    chk("blue", 16'h0200, 16'(ic.blue_gain));
    chk("red", 16'h0200, 16'(ic.red_gain));
    chk("image fields", 16'h8d41, {ic.saturation, ic.sharpen_threshold,
        ic.sharpen_amount, 3'b000, ic.edge_enhance_en});
    for (int a = 0; a < 16; a++) begin
      rdr(8'(a), d);
      chk("reset reg", 16'(exp[a]), 16'(d));
    end
    $display("test reset done");
  endtask

  task automatic t_write();
    logic [7:0] d;
    wr(8'h01, 8'h5a);
    wr(8'h02, 8'h3c);
    wr(8'h0a, 8'h31);
    wr(8'h03, 8'ha7);
    wr(8'h04, 8'h3f);
    wr(8'h07, 8'h9e);
    wr(8'h0e, 8'h7f);
    wr(8'h00, 8'h33);
    chk("blue", 16'h0169, 16'(ic.blue_gain));
    chk("red", 16'h00f3, 16'(ic.red_gain));
    chk("image fields", 16'ha9e0, {ic.saturation, ic.sharpen_threshold,
        ic.sharpen_amount, 3'b000, ic.edge_enhance_en});
    chk("hue on", 16'h002f, 16'({ic.hue_enable, ic.hue_offset}));
    chk("agc", 16'h0033, 16'(ic.agc_gain));
    wr(8'h04, 8'h1f);
    chk("hue off", 16'h0000, 16'({ic.hue_enable, ic.hue_offset}));
    wr(8'h04, 8'h30);
    chk("hue mid", 16'h0020, 16'({ic.hue_enable, ic.hue_offset}));
    rdr(8'h0a, d);
    chk("low bits", 16'h0031, 16'(d));
    $display("test write done");
  endtask

  task automatic t_refuse();
    logic [7:0] d;
    i_host.xfer({8'h82, 8'h00, 8'h77}, 3, 1'b1, rd, ack);
    chk("foreign ack", 16'h0004, 16'(ack & 3'b100));
    repeat (12) @(negedge clk);
    i_host.xfer({DEV_ADDR_WR, 8'h00, 8'h77}, 3, 1'b0, rd, ack);
    chk("disabled ack", 16'h0007, 16'(ack));
    repeat (12) @(negedge clk);
    chk("agc kept", 16'h0033, 16'(ic.agc_gain));
    wr(8'h05, 8'hff);
    rdr(8'h05, d);
    chk("reserved", 16'h0000, 16'(d));
    $display("test refuse done");
  endtask

  task automatic t_auto();
    abl = 8'h5c;
    abp = 1'b1;
    repeat (6) @(negedge clk);
    chk("auto bright", 16'h005c, 16'(ic.brightness));
    abl = 8'h6d;
    wr(8'h06, 8'h11);
    chk("host lost", 16'h006d, 16'(ic.brightness));
    abp = 1'b0;
    repeat (4) @(negedge clk);
    wr(8'h06, 8'h21);
    chk("host kept", 16'h0021, 16'(ic.brightness));
    $display("test auto done");
  endtask

  task automatic t_fsync();
    logic [15:0] n;
    n = 16'h0000;
    repeat (2) begin
      fsync_in = 1'b1;
      repeat (8) begin
        @(negedge clk);
        n = n + 16'(fs_pulse);
      end
      fsync_in = 1'b0;
      repeat (8) @(negedge clk);
    end
    chk("sync pulses", 16'h0002, n);
    $display("test fsync done");
  endtask

  initial begin
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    t_reset();
    t_write();
    t_refuse();
    t_auto();
    t_fsync();
    wrap_up();
  end
endmodule
